// *** hdl/dcs_select.v ***
/*
  Drive command source select: setup and preset source combining,
  profile gating of bus jog and preset, bus silence supervision with
  fallback reaction, readout words and a small register port.
  Assumes bus_* inputs and telegram_ok come from the telegram decoder
  on clk; term_* inputs are raw terminal pins.
  Assumes the readout words are stable drive values on clk and that
  SEC_CYCLES matches the real clock, since every bus time limit is
  counted in whole seconds of it.
*/
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

`include "dcs_map.vh"

module dcs_select #(
  parameter SEC_CYCLES = `DCS_SECOND_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Terminal pins
  input  wire [1:0]  term_setup,
  input  wire [1:0]  term_preset,
  // Telegram decoder
  input  wire        telegram_ok,
  input  wire [1:0]  bus_setup,
  input  wire [1:0]  bus_preset,
  input  wire        bus_jog_one_req,
  input  wire        bus_jog_two_req,
  // Drive readout words
  input  wire [15:0] status_word,
  input  wire [15:0] alarm_word,
  input  wire [15:0] control_word,
  input  wire [15:0] warning_word,
  input  wire [15:0] extended_state_word,
  // Drive control: relay demand input and control outputs
  input  wire        relay_request,
  output reg  [1:0]  active_setup,
  output reg  [1:0]  preset_select,
  output reg         jog_active,
  output reg  [15:0] jog_speed,
  output reg  [2:0]  fallback_mode,
  output reg         trip_out,
  output reg         relay_on,
  output wire        irq
);

  // --------------------------------------------------------------------
  // Combining of two source codes
  // --------------------------------------------------------------------
  function [1:0] dcs_combine;
    input [1:0] src;
    input [1:0] term_code;
    input [1:0] bus_code;
    begin
      case (src)
        `DCS_SRC_TERM: dcs_combine = term_code;
        `DCS_SRC_BUS:  dcs_combine = bus_code;
        `DCS_SRC_AND:  dcs_combine = term_code & bus_code;
        `DCS_SRC_OR:   dcs_combine = term_code | bus_code;
        default:       dcs_combine = term_code;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Terminal synchronisers, one two-stage chain per pin
  // --------------------------------------------------------------------
  wire [3:0] term_pins;
  wire [3:0] term_sync;
  genvar     gi;

  assign term_pins = {term_preset, term_setup};

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_term_sync
      reg meta_reg;
      reg sync_reg;

      // Only the second stage is read, so a metastable first stage never leaks
      always @(posedge clk) begin
        if (!rst_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= term_pins[gi];
          sync_reg <= meta_reg;
        end
      end

      assign term_sync[gi] = sync_reg;
    end
  endgenerate

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  reg [1:0]  setup_src_reg;
  reg [1:0]  preset_src_reg;
  reg [1:0]  profile_reg;
  reg [2:0]  react_reg;
  reg [6:0]  bus_time_reg;
  reg [15:0] jog_one_reg;
  reg [15:0] jog_two_reg;
  reg [15:0] freq_max_reg;
  reg [1:0]  irq_stat_reg;
  reg [1:0]  irq_mask_reg;
  reg        timeout_reg;
  reg        trip_reg;

  wire       wr_stat;
  wire       gap_exceeded;
  wire       timeout_rise;
  wire       comm_resume;
  reg  [6:0] bus_time_next;

  assign wr_stat = reg_wr && (reg_addr == `DCS_OFS_IRQ_STAT);

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  // Out-of-range limits are clamped to the legal 1..99 s window
  always @* begin
    bus_time_next = reg_wdata[6:0];
    if (reg_wdata[31:7] != 25'h0 || reg_wdata[6:0] > `DCS_MAX_BUS_TIME)
      bus_time_next = `DCS_MAX_BUS_TIME;
    else if (reg_wdata[6:0] < `DCS_MIN_BUS_TIME)
      bus_time_next = `DCS_MIN_BUS_TIME;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      setup_src_reg  <= `DCS_RST_SETUP_SRC;
      preset_src_reg <= `DCS_RST_PRESET_SRC;
      profile_reg    <= `DCS_RST_PROFILE;
      react_reg      <= `DCS_RST_REACT;
      bus_time_reg   <= `DCS_RST_BUS_TIME;
      jog_one_reg    <= `DCS_RST_JOG;
      jog_two_reg    <= `DCS_RST_JOG;
      freq_max_reg   <= `DCS_RST_FREQ_MAX;
      irq_mask_reg   <= `DCS_RST_IRQ;
    end else if (reg_wr) begin
      case (reg_addr)
        `DCS_OFS_CTRL: begin
          setup_src_reg  <= reg_wdata[`DCS_CTRL_SETUP_LSB +: 2];
          preset_src_reg <= reg_wdata[`DCS_CTRL_PRESET_LSB +: 2];
          // Profile code 3 is not defined and is refused
          if (reg_wdata[`DCS_CTRL_PROFILE_LSB +: 2] != 2'h3)
            profile_reg <= reg_wdata[`DCS_CTRL_PROFILE_LSB +: 2];
          if (reg_wdata[`DCS_CTRL_REACT_LSB +: 3] <= `DCS_REACT_TRIP)
            react_reg <= reg_wdata[`DCS_CTRL_REACT_LSB +: 3];
        end
        `DCS_OFS_BUS_TIME: bus_time_reg <= bus_time_next;
        `DCS_OFS_JOG_ONE:  jog_one_reg  <= reg_wdata[15:0];
        `DCS_OFS_JOG_TWO:  jog_two_reg  <= reg_wdata[15:0];
        `DCS_OFS_FREQ_MAX: freq_max_reg <= reg_wdata[15:0];
        `DCS_OFS_IRQ_MASK: irq_mask_reg <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Bus silence supervision
  // --------------------------------------------------------------------
  dcs_silence_timer #(
    .SEC_CYCLES   (SEC_CYCLES)
  ) dcs_silence_timer_inst (
    .clk          (clk),
    .rst_n        (rst_n),
    .telegram_ok  (telegram_ok),
    .limit_s      (bus_time_reg),
    .gap_exceeded (gap_exceeded)
  );

  // A telegram in the same cycle wins, so no stray timeout event is logged
  assign timeout_rise = gap_exceeded && !timeout_reg && !telegram_ok;
  assign comm_resume  = telegram_ok && timeout_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      timeout_reg <= 1'b0;
      trip_reg    <= 1'b0;
    end else begin
      // Latched until a good telegram arrives
      if (telegram_ok)
        timeout_reg <= 1'b0;
      else if (gap_exceeded)
        timeout_reg <= 1'b1;
      // A trip is a cut-out: only reset clears it
      if (timeout_rise && react_reg == `DCS_REACT_TRIP)
        trip_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status: bit0 timeout, bit1 resume; set beats clear
  // --------------------------------------------------------------------
  wire [1:0] irq_event;
  wire [1:0] irq_clear;

  assign irq_event = {comm_resume, timeout_rise};
  assign irq_clear = wr_stat ? reg_wdata[1:0] : 2'h0;

  always @(posedge clk) begin
    if (!rst_n)
      irq_stat_reg <= `DCS_RST_IRQ;
    else
      irq_stat_reg <= irq_event | (irq_stat_reg & ~irq_clear);
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // --------------------------------------------------------------------
  // Source selection and profile gating
  // --------------------------------------------------------------------
  reg  [1:0]  bus_preset_gated;
  reg  [15:0] jog_pick;
  reg         jog_req;
  reg  [2:0]  mode_now;
  wire        react_on;

  // Reaction code 0 leaves the relay with the drive
  assign react_on = timeout_reg && (react_reg != `DCS_REACT_OFF);

  always @* begin
    // Bus preset bits ignored outside the native profile
    bus_preset_gated = (profile_reg == `DCS_PROF_NATIVE) ? bus_preset : 2'h0;
    jog_req  = (profile_reg == `DCS_PROF_FIELDBUS) &&
               (bus_jog_one_req || bus_jog_two_req);
    // Jog one wins if both are asked for
    jog_pick = bus_jog_one_req ? jog_one_reg : jog_two_reg;
    if (jog_pick > freq_max_reg)
      jog_pick = freq_max_reg;
    mode_now = timeout_reg ? react_reg : `DCS_REACT_OFF;
  end

  // --------------------------------------------------------------------
  // Registered drive control outputs
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      active_setup  <= 2'h0;
      preset_select <= 2'h0;
      jog_active    <= 1'b0;
      jog_speed     <= 16'h0;
      fallback_mode <= `DCS_REACT_OFF;
      trip_out      <= 1'b0;
      relay_on      <= 1'b0;
    end else begin
      active_setup  <= dcs_combine(setup_src_reg, term_sync[1:0], bus_setup);
      preset_select <= dcs_combine(preset_src_reg, term_sync[3:2],
                                   bus_preset_gated);
      jog_active    <= jog_req;
      jog_speed     <= jog_req ? jog_pick : 16'h0;
      fallback_mode <= mode_now;
      trip_out      <= trip_reg;
      // Relay follows the drive's demand unless a reaction is in force
      relay_on      <= relay_request && !react_on;
    end
  end

  // --------------------------------------------------------------------
  // Read port; readouts exist only here, never on the display path
  // --------------------------------------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0;
    case (reg_addr)
      `DCS_OFS_CTRL:
        rd_mux = {21'h0, react_reg, 2'h0, profile_reg, preset_src_reg, setup_src_reg};
      `DCS_OFS_BUS_TIME:   rd_mux = {25'h0, bus_time_reg};
      `DCS_OFS_JOG_ONE:    rd_mux = {16'h0, jog_one_reg};
      `DCS_OFS_JOG_TWO:    rd_mux = {16'h0, jog_two_reg};
      `DCS_OFS_FREQ_MAX:   rd_mux = {16'h0, freq_max_reg};
      `DCS_OFS_IRQ_STAT:   rd_mux = {30'h0, irq_stat_reg};
      `DCS_OFS_IRQ_MASK:   rd_mux = {30'h0, irq_mask_reg};
      `DCS_OFS_STATE:
        rd_mux = {22'h0, relay_on, trip_reg, timeout_reg, fallback_mode,
                  preset_select, active_setup};
      `DCS_OFS_STATUS_WD:  rd_mux = {16'h0, status_word};
      `DCS_OFS_ALARM_WD:   rd_mux = {16'h0, alarm_word};
      `DCS_OFS_CONTROL_WD: rd_mux = {16'h0, control_word};
      `DCS_OFS_WARN_WD:    rd_mux = {16'h0, warning_word};
      `DCS_OFS_EXT_WD:     rd_mux = {16'h0, extended_state_word};
      default:             rd_mux = 32'h0;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 32'h0;
  end

endmodule // dcs_select
`default_nettype wire

// *** hdl/dcs_map.vh ***
// Behaviour
// - Setup code 00..11 picks setups 1..4, from terminals or from bus.
// - AND mode uses bitwise AND of both codes, OR mode bitwise OR.
// - Preset source from terminals, bus, AND or OR; OR is default.
// - Bus preset selections count only while profile is native code 1.
// - Two bus jog speeds usable only in fieldbus profile 0, default 10,0 Hz.
// - Profile: 0 fieldbus, 1 native (default), 2 fast input-output native.
// - Telegram gap beyond 1..99 s limit (default 1 s) means bus stopped.
// - Timeout reaction: none, hold, stop, jog, max frequency, stop and trip.
// - Any timeout reaction 1..5 in effect drops the output relay.
// - Status, alarm, control and warning words readable as hex values.
// - Readout values are readable only through the plain strobed register port.
/*
  Register map, field positions, reset values and timing for the drive
  command source select block. Definitions only; included by bare name.
*/
`ifndef DCS_MAP_VH
`define DCS_MAP_VH

// ----------------------------------------------------------------------
// Offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define DCS_OFS_CTRL       8'h00
`define DCS_OFS_BUS_TIME   8'h04
`define DCS_OFS_JOG_ONE    8'h08
`define DCS_OFS_JOG_TWO    8'h0C
`define DCS_OFS_FREQ_MAX   8'h10
`define DCS_OFS_IRQ_STAT   8'h14
`define DCS_OFS_IRQ_MASK   8'h18
`define DCS_OFS_STATE      8'h1C
`define DCS_OFS_STATUS_WD  8'h20
`define DCS_OFS_ALARM_WD   8'h24
`define DCS_OFS_CONTROL_WD 8'h28
`define DCS_OFS_WARN_WD    8'h2C
`define DCS_OFS_EXT_WD     8'h30

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DCS_CTRL_SETUP_LSB   0
`define DCS_CTRL_PRESET_LSB  2
`define DCS_CTRL_PROFILE_LSB 4
`define DCS_CTRL_REACT_LSB   8

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define DCS_SRC_TERM   2'h0
`define DCS_SRC_BUS    2'h1
`define DCS_SRC_AND    2'h2
`define DCS_SRC_OR     2'h3
`define DCS_PROF_FIELDBUS 2'h0
`define DCS_PROF_NATIVE   2'h1
`define DCS_PROF_FAST_IO  2'h2
`define DCS_REACT_OFF   3'h0
`define DCS_REACT_HOLD  3'h1
`define DCS_REACT_STOP  3'h2
`define DCS_REACT_JOG   3'h3
`define DCS_REACT_MAX   3'h4
`define DCS_REACT_TRIP  3'h5

// ----------------------------------------------------------------------
// Reset values (frequencies in 0.1 Hz)
// ----------------------------------------------------------------------
`define DCS_RST_SETUP_SRC  2'h3
`define DCS_RST_PRESET_SRC 2'h3
`define DCS_RST_PROFILE    2'h1
`define DCS_RST_REACT      3'h0
`define DCS_RST_BUS_TIME   7'h01
`define DCS_MIN_BUS_TIME   7'h01
`define DCS_MAX_BUS_TIME   7'h63
`define DCS_RST_JOG        16'h0064
`define DCS_RST_FREQ_MAX   16'h01F4
`define DCS_RST_IRQ        2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DCS_CLK_HZ       100000000
`define DCS_SECOND_S     1
`define DCS_SECOND_CYC   (`DCS_CLK_HZ * `DCS_SECOND_S)

`endif

// *** hdl/dcs_silence_timer.v ***
/*
  Bus silence timer: counts whole seconds since the last good telegram
  and flags a gap longer than the limit.
  Assumes telegram_ok is a one-cycle pulse from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "dcs_map.vh"

module dcs_silence_timer #(
  parameter SEC_CYCLES = `DCS_SECOND_CYC
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Control
  input  wire       telegram_ok,
  input  wire [6:0] limit_s,
  // Result
  output reg        gap_exceeded
);

  reg [31:0] tick_reg;
  reg [6:0]  sec_reg;
  wire       sec_wrap;

  assign sec_wrap = (tick_reg == SEC_CYCLES - 1);

  always @(posedge clk) begin
    if (!rst_n) begin
      tick_reg     <= 32'h0;
      sec_reg      <= 7'h0;
      gap_exceeded <= 1'b0;
    end else if (telegram_ok) begin
      tick_reg     <= 32'h0;
      sec_reg      <= 7'h0;
      gap_exceeded <= 1'b0;
    end else begin
      tick_reg <= sec_wrap ? 32'h0 : tick_reg + 32'h1;
      // Saturate so a long silence never wraps back to quiet
      if (sec_wrap && sec_reg != 7'h7F)
        sec_reg <= sec_reg + 7'h1;
      if (sec_reg > limit_s)
        gap_exceeded <= 1'b1;
    end
  end

endmodule // dcs_silence_timer
`default_nettype wire

// *** dv/dcs_monitor.sv ***
/*
  Checker for dcs_select: output relations over time.
  Assumes it is bound to dcs_select and shares its SEC_CYCLES.
*/
`timescale 1ns/1ps
`default_nettype none

module dcs_monitor #(
  parameter SEC_CYCLES = 20
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  // Telegram side
  input  wire logic        telegram_ok,
  input  wire logic        bus_jog_one_req,
  input  wire logic        bus_jog_two_req,
  // Drive control
  input  wire logic        relay_request,
  input  wire logic        jog_active,
  input  wire logic [15:0] jog_speed,
  input  wire logic [2:0]  fallback_mode,
  input  wire logic        trip_out,
  input  wire logic        relay_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Cycles since the last telegram; a timeout needs more than one second
  logic [31:0] quiet_reg;
  always @(posedge clk) begin
    if (!rst_n || telegram_ok) quiet_reg <= 32'h0;
    else quiet_reg <= quiet_reg + 32'h1;
  end

  relay_drop_a: assert property (fallback_mode != 3'h0 |-> !relay_on)
    else $error("relay on during timeout reaction");
  relay_cause_a: assert property ($rose(relay_on) |-> $past(relay_request))
    else $error("relay rose without demand");
  react_range_a: assert property (fallback_mode <= 3'h5)
    else $error("reaction code out of range");
  trip_cause_a: assert property ($rose(trip_out) |-> fallback_mode == 3'h5)
    else $error("cut-out without stop and trip reaction");
  trip_hold_a: assert property (trip_out |=> trip_out)
    else $error("cut-out released before reset");
  jog_zero_a: assert property (!jog_active |-> jog_speed == 16'h0)
    else $error("jog speed without jog");
  jog_cause_a: assert property (jog_active |-> $past(bus_jog_one_req || bus_jog_two_req))
    else $error("jog without bus request");
  read_stand_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  resume_clear_a: assert property (telegram_ok |-> ##[1:3] fallback_mode == 3'h0)
    else $error("reaction kept after telegram");
  gap_bound_a: assert property ($rose(fallback_mode != 3'h0) |-> quiet_reg > SEC_CYCLES)
    else $error("timeout before the limit");

  cover property ($rose(fallback_mode != 3'h0));
  cover property ($rose(trip_out));
  cover property ($rose(jog_active));
endmodule // dcs_monitor

`default_nettype wire

// *** dv/dcs_partner.sv ***
/*
  Serial master model: one telegram every gap+1 cycles while enabled.
  Assumes the bench changes the commanded codes right after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module dcs_partner (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bench commands
  input  wire logic       send_en,
  input  wire logic [7:0] gap,
  input  wire logic [1:0] nx_setup,
  input  wire logic [1:0] nx_preset,
  input  wire logic       nx_jog1,
  input  wire logic       nx_jog2,
  // Telegram side
  output logic            telegram_ok,
  output logic [1:0]      bus_setup,
  output logic [1:0]      bus_preset,
  output logic            bus_jog_one_req,
  output logic            bus_jog_two_req
);
  logic [7:0] cnt_reg;

  // New codes only land with a telegram, as from a real decoder
  always @(posedge clk) begin
    telegram_ok <= 1'b0;
    cnt_reg <= cnt_reg + 8'h01;
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      bus_setup <= 2'h0;
      bus_preset <= 2'h0;
      bus_jog_one_req <= 1'b0;
      bus_jog_two_req <= 1'b0;
    end else if (send_en && cnt_reg >= gap) begin
      cnt_reg <= 8'h00;
      telegram_ok <= 1'b1;
      bus_setup <= nx_setup;
      bus_preset <= nx_preset;
      bus_jog_one_req <= nx_jog1;
      bus_jog_two_req <= nx_jog2;
    end
  end
endmodule // dcs_partner

`default_nettype wire

// *** dv/dcs_select_tb.sv ***
/*
  Self-checking bench for dcs_select with the serial master model.
  Assumes a short second (SEC_CYCLES) so timeouts stay brief.
*/
`timescale 1ns/1ps
`default_nettype none

module dcs_select_tb;
  localparam int SEC = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [1:0]  term_setup = 2'h0;
  logic [1:0]  term_preset = 2'h0;
  logic        relay_request = 1'b0;
  logic        send_en = 1'b1;
  logic [7:0]  gap = 8'h03;
  logic [1:0]  nx_setup = 2'h0;
  logic [1:0]  nx_preset = 2'h0;
  logic        nx_jog1 = 1'b0;
  logic        nx_jog2 = 1'b0;
  logic [15:0] wd [5] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'h0F1E};
  logic [31:0] reg_rdata;
  logic        telegram_ok, jog_one, jog_two, jog_active, trip_out, relay_on, irq;
  logic [1:0]  bus_setup, bus_preset, active_setup, preset_select;
  logic [15:0] jog_speed;
  logic [2:0]  fallback_mode;
  int          n_fail = 0;
  int          total_checks = 0;

  always #5 clk = ~clk;

  dcs_partner dcs_partner_inst (.clk(clk), .rst_n(rst_n), .send_en(send_en), .gap(gap),
    .nx_setup(nx_setup), .nx_preset(nx_preset), .nx_jog1(nx_jog1), .nx_jog2(nx_jog2),
    .telegram_ok(telegram_ok), .bus_setup(bus_setup), .bus_preset(bus_preset),
    .bus_jog_one_req(jog_one), .bus_jog_two_req(jog_two));

  dcs_select #(.SEC_CYCLES(SEC)) dcs_select_inst (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .term_setup(term_setup), .term_preset(term_preset),
    .telegram_ok(telegram_ok), .bus_setup(bus_setup), .bus_preset(bus_preset),
    .bus_jog_one_req(jog_one), .bus_jog_two_req(jog_two), .status_word(wd[0]),
    .alarm_word(wd[1]), .control_word(wd[2]), .warning_word(wd[3]),
    .extended_state_word(wd[4]), .relay_request(relay_request),
    .active_setup(active_setup), .preset_select(preset_select), .jog_active(jog_active),
    .jog_speed(jog_speed), .fallback_mode(fallback_mode), .trip_out(trip_out),
    .relay_on(relay_on), .irq(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  function automatic logic [1:0] comb(input int m, input logic [1:0] b, input logic [1:0] t);
    case (m)
      0: return t;
      1: return b;
      2: return b & t;
      default: return b | t;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    int i;
    rchk(8'h00, 32'h1F);
    rchk(8'h04, 32'h1);
    rchk(8'h08, 32'h64);
    rchk(8'h0C, 32'h64);
    rchk(8'h40, 32'h0);
    wr(8'h20, 32'hFFFF);
    for (i = 0; i < 5; i++) rchk(8'h20 + 8'(4 * i), {16'h0, wd[i]});
  endtask

  task automatic t_select;
    int m;
    int c;
    for (m = 0; m < 4; m++) begin
      wr(8'h00, {26'h0, 2'h1, 2'(m), 2'(m)});
      for (c = 0; c < 16; c++) begin
        nx_setup <= c[3:2];
        term_setup <= c[1:0];
        nx_preset <= c[1:0];
        term_preset <= c[3:2];
        settle(10);
        chk(active_setup, comb(m, c[3:2], c[1:0]));
        chk(preset_select, comb(m, c[1:0], c[3:2]));
      end
    end
    wr(8'h00, 32'h05);
    settle(10);
    chk(preset_select, 32'h0);
    wr(8'h00, 32'h25);
    settle(3);
    chk(preset_select, 32'h0);
  endtask

  task automatic t_jog;
    wr(8'h0C, 32'h32);
    wr(8'h00, 32'h0F);
    nx_jog1 <= 1'b1;
    nx_jog2 <= 1'b1;
    settle(10);
    chk(jog_active, 1'b1);
    chk(jog_speed, 32'h64);
    nx_jog1 <= 1'b0;
    settle(10);
    chk(jog_speed, 32'h32);
    wr(8'h10, 32'h20);
    settle(3);
    chk(jog_speed, 32'h20);
    wr(8'h00, 32'h2F);
    settle(3);
    chk(jog_active, 1'b0);
    wr(8'h00, 32'h63F);
    rchk(8'h00, 32'h2F);
    nx_jog2 <= 1'b0;
    wr(8'h10, 32'h1F4);
  endtask

  task automatic t_timeout;
    int r;
    int k;
    relay_request <= 1'b1;
    wr(8'h18, 32'h1);
    wr(8'h04, 32'h0);
    rchk(8'h04, 32'h1);
    wr(8'h04, 32'hC8);
    rchk(8'h04, 32'h63);
    wr(8'h04, 32'h2);
    // A slow but timely master must never trip the supervision
    gap <= 8'd30;
    settle(100);
    chk(irq, 1'b0);
    gap <= 8'h03;
    for (r = 0; r < 6; r++) begin
      wr(8'h00, {21'h0, 3'(r), 8'h1F});
      send_en <= 1'b0;
      settle(2 * SEC);
      chk(irq, 1'b0);
      for (k = 0; k < 40 && irq !== 1'b1; k++) @(posedge clk);
      settle(2);
      chk(irq, 1'b1);
      chk(fallback_mode, 32'(r));
      chk(relay_on, r == 0);
      chk(trip_out, r == 5);
      rchk(8'h1C, {22'h0, 1'(r == 0), 1'(r == 5), 1'b1, 3'(r), 4'hF});
      send_en <= 1'b1;
      settle(10);
      chk(fallback_mode, 32'h0);
      chk(relay_on, 1'b1);
      rchk(8'h14, 32'h3);
      wr(8'h18, 32'h0);
      settle(1);
      chk(irq, 1'b0);
      wr(8'h18, 32'h1);
      wr(8'h14, 32'h3);
      settle(1);
      chk(irq, 1'b0);
    end
    do_reset;
    settle(1);
    chk(trip_out, 1'b0);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    do_reset;
    t_regs;
    t_select;
    t_jog;
    t_timeout;
    print_verdict;
  end

  // Whole run is under two thousand cycles; this span leaves ample margin
  initial begin
    #200000;
    n_fail++;
    print_verdict;
  end
endmodule // dcs_select_tb

bind dcs_select dcs_monitor #(.SEC_CYCLES(SEC_CYCLES)) dcs_monitor_inst (.clk(clk),
  .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .telegram_ok(telegram_ok),
  .bus_jog_one_req(bus_jog_one_req), .bus_jog_two_req(bus_jog_two_req),
  .relay_request(relay_request), .jog_active(jog_active), .jog_speed(jog_speed),
  .fallback_mode(fallback_mode), .trip_out(trip_out), .relay_on(relay_on));

`default_nettype wire
